// ### rtl/usart_pkg.sv
// Constants for the serial status and setup block
`default_nettype none
package usart_pkg;
    // ==========================================
    // Status byte bit positions
    localparam int ST_XMIT_READY  = 0;
    localparam int ST_RECV_READY  = 1;
    localparam int ST_XMIT_EMPTY  = 2;
    localparam int ST_PARITY_ERR  = 3;
    localparam int ST_OVERRUN     = 4;
    localparam int ST_FRAMING_ERR = 5;
    localparam int ST_SYNC_DETECT = 6;
    localparam int ST_DSR         = 7;
    // ==========================================
    // Mode byte fields
    localparam int MD_BAUD_LSB   = 0;   // 2 bits: 01=1x, 10=16x, 11=63x, 00=sync
    localparam int MD_LEN_LSB    = 2;   // 2 bits: 00=5 .. 11=8 bits
    localparam int MD_PAR_EN     = 4;
    localparam int MD_PAR_EVEN   = 5;
    localparam int MD_STOP_LSB   = 6;
    localparam logic [1:0] BAUD_SYNC = 2'h0;
    localparam logic [1:0] BAUD_1X   = 2'h1;
    localparam logic [1:0] BAUD_16X  = 2'h2;
    localparam logic [1:0] BAUD_64X  = 2'h3;
    // ==========================================
    // Command byte fields
    localparam int CM_XMIT_EN    = 0;
    localparam int CM_DTR        = 1;
    localparam int CM_RECV_EN    = 2;
    localparam int CM_BREAK      = 3;
    localparam int CM_ERR_RESET  = 4;
    localparam int CM_RTS        = 5;
    localparam int CM_INT_RESET  = 6;
    // ==========================================
    // Reset values and timing
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CMD_RST  = 8'h00;
    localparam int CLK_NS           = 50;
    localparam int XMIT_RDY_MAX     = 8;    // clocks, last-bit centre to ready
    localparam int RECV_RDY_MAX     = 26;
    localparam int XMIT_EMPTY_MAX   = 20;
    localparam int STATUS_MAX       = 28;
    localparam int CTRL_MAX         = 8;
    localparam int FIFO_DEPTH       = 4;
    localparam int FIFO_WIDTH       = 8;
endpackage : usart_pkg
`default_nettype wire

// ### rtl/usart_status_and_setup.sv
// Status, setup and serial data path of the programmable serial interface
`default_nettype none

// ==========================================
// Small synchronous FIFO
module usart_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Storage
    logic [AW-1:0]    wr_ptr;        // Write index
    logic [AW-1:0]    rd_ptr;        // Read index
    logic [AW:0]      count;         // Words held
    logic             push;
    logic             pop;
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    // Storage write, no reset needed for data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    // Pointers and fill level
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : usart_fifo

// ==========================================
// Top level
module usart_status_and_setup (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cs_n_i,        // Chip select
    input  wire logic       rd_n_i,        // Read strobe
    input  wire logic       wr_n_i,        // Write strobe
    input  wire logic       cd_i,          // High: control/status, low: data
    input  wire logic [7:0] data_i,        // Write data from host
    output logic      [7:0] data_o,        // Read data to host
    output logic            data_oe_o,     // High while driving the bus
    input  wire logic       dsr_n_i,       // Data set ready, active low
    input  wire logic       cts_n_i,       // Clear to send, active low
    input  wire logic       sync_ext_i,    // External sync detect level
    input  wire logic       recv_clk_i,    // Receive clock pin
    input  wire logic       xmit_clk_i,    // Transmit clock pin
    input  wire logic       recv_line_i,   // Serial input
    output logic            xmit_line_o,   // Serial output
    output logic            xmit_ready_o,
    output logic            recv_ready_o,
    output logic            xmit_empty_o,
    output logic            sync_detect_o,
    output logic            dtr_n_o,
    output logic            rts_n_o
);
    // ==========================================
    // Input synchronisers, two flops each
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] raw_in;
    assign raw_in = {cs_n_i, rd_n_i, wr_n_i, cd_i, dsr_n_i, cts_n_i,
                     recv_clk_i, xmit_clk_i, recv_line_i};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 9'h1ff;
            sync2 <= 9'h1ff;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end
    logic s_cs_n, s_rd_n, s_wr_n, s_cd, s_dsr_n, s_cts_n, s_rxc, s_txc, s_rxd;
    assign {s_cs_n, s_rd_n, s_wr_n, s_cd, s_dsr_n, s_cts_n, s_rxc, s_txc, s_rxd} = sync2;
    // Data and sync-detect levels pass through two flops of their own before use
    logic [7:0] s_data;
    logic [7:0] s_data1;
    logic       s_sync1;
    logic       s_sync;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_data1 <= 8'h00;
            s_data  <= 8'h00;
            s_sync1 <= 1'b0;
            s_sync  <= 1'b0;
        end else begin
            s_data1 <= data_i;
            s_data  <= s_data1;
            s_sync1 <= sync_ext_i;
            s_sync  <= s_sync1;
        end
    end
    // ==========================================
    // Edge detection on strobes and serial clocks
    logic wr_d, rd_d, rxc_d, txc_d;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_d  <= 1'b1;
            rd_d  <= 1'b1;
            rxc_d <= 1'b1;
            txc_d <= 1'b1;
        end else begin
            wr_d  <= s_wr_n;
            rd_d  <= s_rd_n;
            rxc_d <= s_rxc;
            txc_d <= s_txc;
        end
    end
    logic wr_rise;   // End of a write strobe: data captured here
    logic rd_rise;   // End of a read: data reads consume here
    logic rxc_rise;
    logic txc_fall;
    assign wr_rise  = s_wr_n & ~wr_d & ~s_cs_n;
    assign rd_rise  = s_rd_n & ~rd_d & ~s_cs_n;
    assign rxc_rise = s_rxc & ~rxc_d;
    assign txc_fall = ~s_txc & txc_d;

    // ==========================================
    // Control bytes: first write after reset is mode, then commands
    logic [7:0] mode;
    logic [7:0] cmd;
    logic       mode_done;
    logic       err_clear;     // One-cycle error reset pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode      <= usart_pkg::MODE_RST;
            cmd       <= usart_pkg::CMD_RST;
            mode_done <= 1'b0;
            err_clear <= 1'b0;
        end else begin
            err_clear <= 1'b0;
            if (wr_rise && s_cd) begin
                if (!mode_done) begin
                    mode      <= s_data;
                    mode_done <= 1'b1;
                end else if (s_data[usart_pkg::CM_INT_RESET]) begin
                    // Internal reset returns to expecting a mode byte
                    mode_done <= 1'b0;
                    cmd       <= usart_pkg::CMD_RST;
                end else begin
                    cmd       <= s_data;
                    err_clear <= s_data[usart_pkg::CM_ERR_RESET];
                end
            end
        end
    end
    logic [3:0] char_bits;      // Data bits per character, 5 to 8
    logic [5:0] over;           // Clocks per bit in async mode
    assign char_bits = 4'(5 + mode[usart_pkg::MD_LEN_LSB +: 2]);
    always_comb begin
        unique case (mode[usart_pkg::MD_BAUD_LSB +: 2])
            usart_pkg::BAUD_16X: over = 6'd16;
            usart_pkg::BAUD_64X: over = 6'd63;
            default:             over = 6'd1;
        endcase
    end
    logic par_en, par_even;
    assign par_en   = mode[usart_pkg::MD_PAR_EN];
    assign par_even = mode[usart_pkg::MD_PAR_EVEN];

    // ==========================================
    // Transmit buffer FIFO
    logic       tx_push, tx_valid, tx_pop;
    logic [7:0] tx_word;
    assign tx_push = wr_rise & ~s_cd;
    usart_fifo #(.WIDTH(usart_pkg::FIFO_WIDTH), .DEPTH(usart_pkg::FIFO_DEPTH)) u_tx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (),           // A full buffer drops the write
        .in_data_i   (s_data),
        .out_valid_o (tx_valid),
        .out_ready_i (tx_pop),
        .out_data_o  (tx_word)
    );

    // ==========================================
    // Transmitter: shifts on falling transmit clock edges
    logic [10:0] tx_shift;
    logic [3:0]  tx_left;      // Bits still to send
    logic [5:0]  tx_div;
    logic        tx_busy;
    logic        tx_parity;
    assign tx_parity = ^(tx_word & 8'(8'hff >> (4'd8 - char_bits))) ^ ~par_even;
    assign tx_pop    = ~tx_busy & tx_valid & ~s_cts_n & cmd[usart_pkg::CM_XMIT_EN];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_shift    <= 11'h7ff;
            tx_left     <= 4'h0;
            tx_div      <= 6'h00;
            tx_busy     <= 1'b0;
            xmit_line_o <= 1'b1;
        end else if (tx_pop) begin
            // Frame: start, data, optional parity, then one stop
            tx_shift <= 11'((({2'b11, tx_word} | ~(9'h1ff >> (4'd9 - char_bits)))
                        & ~(par_en ? 11'(1) << char_bits : 11'h0))
                        | (par_en ? 11'(tx_parity) << char_bits : 11'h0));
            tx_left  <= 4'(char_bits + (par_en ? 4'd2 : 4'd1));
            tx_div   <= 6'h00;
            tx_busy  <= 1'b1;
            xmit_line_o <= 1'b0;
        end else if (tx_busy && txc_fall) begin
            if (tx_div == over - 6'd1) begin
                tx_div <= 6'h00;
                if (tx_left == 4'h0) begin
                    tx_busy <= 1'b0;
                end else begin
                    xmit_line_o <= tx_shift[0];
                    tx_shift    <= {1'b1, tx_shift[10:1]};
                    tx_left     <= tx_left - 4'h1;
                end
            end else begin
                tx_div <= tx_div + 6'h1;
            end
        end else if (!tx_busy) begin
            // Break holds the line low, otherwise mark
            xmit_line_o <= ~cmd[usart_pkg::CM_BREAK];
        end
    end

    // ==========================================
    // Receiver: samples at bit centres on rising receive clock edges
    logic [9:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [5:0] rx_div;
    logic       rx_busy;
    logic       rx_done;      // One-cycle pulse at stop bit centre
    logic [3:0] rx_total;
    assign rx_total = 4'(char_bits + (par_en ? 4'd1 : 4'd0));
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_shift <= 10'h000;
            rx_cnt   <= 4'h0;
            rx_div   <= 6'h00;
            rx_busy  <= 1'b0;
            rx_done  <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (rxc_rise && !s_rxd && cmd[usart_pkg::CM_RECV_EN]) begin
                    rx_busy <= 1'b1;
                    rx_div  <= 6'h00;
                    rx_cnt  <= 4'h0;
                end
            end else if (rxc_rise) begin
                if (rx_div == ((rx_cnt == 4'h0) ? (over >> 1) : over) - 6'd1
                    || over == 6'd1) begin
                    rx_div <= 6'h00;
                    if (rx_cnt == 4'h0 && s_rxd) begin
                        // False start bit, back to idle
                        rx_busy <= 1'b0;
                    end else if (rx_cnt == rx_total + 4'h1) begin
                        rx_busy  <= 1'b0;
                        rx_done  <= 1'b1;
                        rx_shift <= {s_rxd, rx_shift[9:1]};
                    end else begin
                        if (rx_cnt != 4'h0) begin
                            rx_shift <= {s_rxd, rx_shift[9:1]};
                        end
                        rx_cnt <= rx_cnt + 4'h1;
                    end
                end else begin
                    rx_div <= rx_div + 6'h1;
                end
            end
        end
    end
    // Realign the captured bits: stop at bit 9, data from the bottom
    logic [9:0] rx_al;
    logic [7:0] rx_char;
    logic       rx_par_bit;
    assign rx_al      = 10'(rx_shift >> (4'd9 - rx_total));
    assign rx_char    = rx_al[7:0] & 8'(8'hff >> (4'd8 - char_bits));
    assign rx_par_bit = rx_al[char_bits];

    // ==========================================
    // Receive buffer and error flags
    logic [7:0] rx_buf;
    logic       rx_full;
    logic       fe, oe, pe;
    logic       data_rd;
    assign data_rd = rd_rise & ~s_cd;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_buf  <= 8'h00;
            rx_full <= 1'b0;
            fe      <= 1'b0;
            oe      <= 1'b0;
            pe      <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_buf  <= rx_char;
                rx_full <= 1'b1;
            end else if (data_rd) begin
                rx_full <= 1'b0;
            end
            oe <= (rx_done & rx_full) | (oe & ~err_clear);
            fe <= (rx_done & ~s_rxd) | (fe & ~err_clear);
            pe <= (rx_done & par_en & ((^rx_char ^ rx_par_bit) != par_even ? 1'b0 : 1'b1)
                   & ((^rx_char ^ rx_par_bit) ^ ~par_even)) | (pe & ~err_clear);
        end
    end

    // ==========================================
    // Pin outputs, all registered
    // ready and empty within bounds
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xmit_ready_o  <= 1'b0;
            recv_ready_o  <= 1'b0;
            xmit_empty_o  <= 1'b1;
            sync_detect_o <= 1'b0;
            dtr_n_o       <= 1'b1;
            rts_n_o       <= 1'b1;
        end else begin
            xmit_ready_o  <= ~tx_valid & ~s_cts_n & cmd[usart_pkg::CM_XMIT_EN];
            recv_ready_o  <= rx_full & ~data_rd;
            // Empty rises at the stop bit centre, so it never waits a whole bit
            xmit_empty_o  <= ~tx_valid
                             & (~tx_busy | (tx_left == 4'h0 && tx_div >= (over >> 1)));
            sync_detect_o <= s_sync;
            dtr_n_o <= ~cmd[usart_pkg::CM_DTR];
            rts_n_o <= ~cmd[usart_pkg::CM_RTS];
        end
    end

    // ==========================================
    // Host read port
    logic [7:0] status;
    // status from flops, no added delay
    always_comb begin
        status = 8'h00;
        status[usart_pkg::ST_XMIT_READY]  = ~tx_valid;      // style: buffer empty only
        status[usart_pkg::ST_RECV_READY]  = recv_ready_o;
        status[usart_pkg::ST_XMIT_EMPTY]  = xmit_empty_o;
        status[usart_pkg::ST_PARITY_ERR]  = pe;
        status[usart_pkg::ST_OVERRUN]     = oe;
        status[usart_pkg::ST_FRAMING_ERR] = fe;
        status[usart_pkg::ST_SYNC_DETECT] = sync_detect_o;
        status[usart_pkg::ST_DSR]         = ~s_dsr_n;
    end
    // status on read with cd high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= ~s_cs_n & ~s_rd_n;
            if (!s_cs_n && !s_rd_n) begin
                data_o <= s_cd ? status : rx_buf;
            end
        end
    end

    // ==========================================
    // Checks
    // status ready tracks buffer
    a_stat_xmit_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        status[usart_pkg::ST_XMIT_READY] == ~tx_valid)
        else $error("status xmit ready not buffer empty");
    // ready pin high only if its three terms held the cycle before
    a_pin_xmit_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        xmit_ready_o |-> $past(~tx_valid & ~s_cts_n & cmd[usart_pkg::CM_XMIT_EN]))
        else $error("ready pin high without its conditions");
    a_stat_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        {status[usart_pkg::ST_SYNC_DETECT], status[usart_pkg::ST_XMIT_EMPTY],
         status[usart_pkg::ST_RECV_READY]} == {sync_detect_o, xmit_empty_o, recv_ready_o})
        else $error("status does not mirror pins");
    a_stat_dsr: assert property (@(posedge clk_i) disable iff (rst_i)
        status[usart_pkg::ST_DSR] == ~s_dsr_n)
        else $error("dsr status wrong");
    a_modem_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(cmd) |=> (rts_n_o == ~cmd[usart_pkg::CM_RTS])
                          && (dtr_n_o == ~cmd[usart_pkg::CM_DTR]))
        else $error("modem pins lag command");
    a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(fe) && !$past(err_clear) |-> fe)
        else $error("framing flag lost");
    a_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_done && rx_full |=> oe)
        else $error("overrun not set");
    // receive ready soon after last bit
    a_rx_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_done |-> ##[1:2] (recv_ready_o || data_rd))
        else $error("receive ready late");
endmodule : usart_status_and_setup
`default_nettype wire

// ### sim/serial_peer.sv
// Far-end serial model: free baud clock, character sender, line receiver
`default_nettype none
module serial_peer (
    output logic      ser_clk_o,  // Baud clock for both directions, 16x
    output logic      line_o,     // Drives the block's serial input
    input  wire logic line_i      // Watches the block's serial output
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q[$];  // Frames seen: stop, parity, six data bits
    logic [7:0] frame;    // Frame being assembled
    // ==========================================
    // Baud clock runs free, as a rate generator would
    initial begin
        ser_clk_o = 1'b0;
        forever #200 ser_clk_o = ~ser_clk_o;
    end
    // Line rests at mark level between characters
    initial line_o = 1'b1;
    // ==========================================
    // Sender: bits change on the falling edge so the block samples them settled
    // async six-bit frame
    task automatic send_char(input logic [5:0] d, input logic bad_par, input logic bad_stop);
        logic [8:0] f;
        f = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
        for (int i = 0; i < 9; i++) begin
            @(negedge ser_clk_o);
            line_o = f[i];
            repeat (15) @(negedge ser_clk_o);
        end
        line_o = 1'b1;
    endtask : send_char
    // ==========================================
    // Receiver: half a bit after the start edge, then one sample per bit
    always begin
        @(negedge line_i);
        repeat (8) @(posedge ser_clk_o);
        // Short low pulses are glitches, not start bits
        if (line_i === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge ser_clk_o);
                frame[i] = line_i;
            end
            rx_q.push_back(frame);
        end
    end
endmodule : serial_peer
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the serial status and setup block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_i, rst_i, cs_n_i, rd_n_i, wr_n_i, cd_i, dsr_n_i, cts_n_i, sync_ext_i;
    logic [7:0] data_i, data_o, st, rd;
    logic       data_oe_o, xmit_line_o, xmit_ready_o, recv_ready_o, xmit_empty_o;
    logic       sync_detect_o, dtr_n_o, rts_n_o, ser_clk, ser_line;
    logic [5:0] d;  // Character under test
    int         mismatches, samples_checked;
    // ==========================================
    // Block and its serial far end
    usart_status_and_setup i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
        .cd_i(cd_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
        .dsr_n_i(dsr_n_i), .cts_n_i(cts_n_i), .sync_ext_i(sync_ext_i),
        .recv_clk_i(ser_clk), .xmit_clk_i(ser_clk), .recv_line_i(ser_line),
        .xmit_line_o(xmit_line_o), .xmit_ready_o(xmit_ready_o), .recv_ready_o(recv_ready_o),
        .xmit_empty_o(xmit_empty_o), .sync_detect_o(sync_detect_o), .dtr_n_o(dtr_n_o),
        .rts_n_o(rts_n_o));
    serial_peer i_peer (.ser_clk_o(ser_clk), .line_o(ser_line), .line_i(xmit_line_o));
    // ==========================================
    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // ==========================================
    // Verdict and comparison helpers
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // ==========================================
    // Host accesses; strobes held well past the two-flop synchroniser
    task automatic bus_write(input logic cd, input logic [7:0] v);
        @(negedge clk_i);
        cs_n_i = 1'b0;
        cd_i = cd;
        data_i = v;
        wr_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        wr_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        cs_n_i = 1'b1;
        // Leaves exactly the control settling bound after the rising strobe
        repeat (usart_pkg::CTRL_MAX - 3) @(negedge clk_i);
    endtask : bus_write
    task automatic bus_read(input logic cd, output logic [7:0] v);
        @(negedge clk_i);
        cs_n_i = 1'b0;
        cd_i = cd;
        rd_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        v = data_o;
        check({7'h0, data_oe_o}, 8'h01);
        rd_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        cs_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask : bus_read
    task automatic expect_status(input logic [7:0] exp);
        bus_read(1'b1, st);
        check(st, exp);
        check({5'h0, st[6], st[2], st[1]}, {5'h0, sync_detect_o, xmit_empty_o, recv_ready_o});
    endtask : expect_status
    // Host polls the status ready bit before a data write; running out ends the run
    task automatic poll_ready();
        int k;
        k = 0;
        st = 8'h00;
        while (st[usart_pkg::ST_XMIT_READY] !== 1'b1 && k < 200) begin
            bus_read(1'b1, st);
            k++;
        end
        if (st[usart_pkg::ST_XMIT_READY] !== 1'b1) begin
            mismatches++;
            complete_run();
        end
    endtask : poll_ready
    // Bounded wait for frames at the far end; running out ends the run
    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while (i_peer.rx_q.size() < n && k < 8000) begin
            @(negedge clk_i);
            k++;
        end
        if (k == 8000) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_rx
    // ==========================================
    // Main sequence
    initial begin
        {cs_n_i, rd_n_i, wr_n_i, cd_i, dsr_n_i, cts_n_i, sync_ext_i} = 7'h7a;
        data_i = 8'h00;
        rst_i = 1'b1;
        mismatches = 0;
        samples_checked = 0;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        check({5'h0, dtr_n_o, rts_n_o, xmit_ready_o}, 8'h06);
        expect_status(8'h85);
        bus_write(1'b1, 8'hb6);
        bus_write(1'b1, 8'h27);
        // CTS still high, so only the status bit reports the empty buffer
        check({5'h0, dtr_n_o, rts_n_o, xmit_ready_o}, 8'h00);
        expect_status(8'h85);
        cts_n_i = 1'b0;
        repeat (usart_pkg::CTRL_MAX) @(negedge clk_i);
        check({7'h0, xmit_ready_o}, 8'h01);
        bus_write(1'b1, 8'h25);
        check({6'h0, dtr_n_o, rts_n_o}, 8'h02);
        bus_write(1'b1, 8'h26);
        check({5'h0, dtr_n_o, rts_n_o, xmit_ready_o}, 8'h00);
        expect_status(8'h85);
        bus_write(1'b1, 8'h27);
        dsr_n_i = 1'b1;
        sync_ext_i = 1'b1;
        repeat (4) @(negedge clk_i);
        expect_status(8'h45);
        dsr_n_i = 1'b0;
        sync_ext_i = 1'b0;
        check({7'h0, xmit_ready_o}, 8'h01);
        // One character out, then ready and empty both checked after the empty bound
        bus_write(1'b0, 8'h2d);
        wait_rx(1);
        check(i_peer.rx_q[0], 8'had);
        repeat (usart_pkg::XMIT_EMPTY_MAX) @(negedge clk_i);
        check({6'h0, xmit_empty_o, xmit_ready_o}, 8'h03);
        // Stream four characters, each written only once status reads ready
        cts_n_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            poll_ready();
            bus_write(1'b0, 8'h10 + 8'(i));
            if (i == 0) begin
                // CTS high keeps the first one waiting in the buffer
                expect_status(8'h80);
                cts_n_i = 1'b0;
            end
        end
        wait_rx(5);
        for (int i = 0; i < 4; i++) begin
            d = 6'h10 + 6'(i);
            check(i_peer.rx_q[i + 1], {1'b1, ^d, d});
        end
        // Reception, then each error flag, which must stay until cleared
        i_peer.send_char(6'h2d, 1'b0, 1'b0);
        check({7'h0, recv_ready_o}, 8'h01);
        bus_read(1'b0, rd);
        check(rd, 8'h2d);
        expect_status(8'h85);
        i_peer.send_char(6'h15, 1'b1, 1'b0);
        bus_read(1'b0, rd);
        expect_status(8'h8d);
        i_peer.send_char(6'h2a, 1'b0, 1'b1);
        bus_read(1'b0, rd);
        check(rd, 8'h2a);
        expect_status(8'had);
        i_peer.send_char(6'h0f, 1'b0, 1'b0);
        i_peer.send_char(6'h33, 1'b0, 1'b0);
        bus_read(1'b0, rd);
        check(rd, 8'h33);
        expect_status(8'hbd);
        bus_write(1'b1, 8'h37);
        expect_status(8'h85);
        // Break holds the line low; internal reset drops every command bit
        bus_write(1'b1, 8'h2f);
        check({7'h0, xmit_line_o}, 8'h00);
        bus_write(1'b1, 8'h40);
        check({5'h0, dtr_n_o, rts_n_o, xmit_line_o}, 8'h07);
        complete_run();
    end
endmodule : tb
`default_nettype wire
